/* File: common/pfs_map.svh */
// Register map, field positions and reset values of the function status bank
// ==========================================================================
`ifndef PFS_MAP_SVH
`define PFS_MAP_SVH

// ==========================================================================
// Byte offsets on the register bus
`define PFS_OFS_STATUS   4'h0
`define PFS_OFS_IRQ_STAT 4'h4
`define PFS_OFS_IRQ_MASK 4'h8
`define PFS_OFS_CTRL     4'hc
`define PFS_ADDR_W       4

// ==========================================================================
// Status field positions
`define PFS_BIT_RECEIVED_MASTER_ABORT_FLAG   13
`define PFS_BIT_TABTREC  12
`define PFS_BIT_TABTSIG  11
`define PFS_BIT_TIM_HI   10
`define PFS_BIT_TIM_LO   9
`define PFS_BIT_PAR      8
`define PFS_TIMING_CODE  2'h1
`define PFS_CAPABILITY_LIST_PRESENT_VAL  1'h1
`define PFS_HARD_ZERO    1'h0
`define PFS_RSVD_VAL     4'h0

// ==========================================================================
// Event bit positions (interrupt status and mask)
`define PFS_EV_RECEIVED_MASTER_ABORT_FLAG    0
`define PFS_EV_TABTREC   1
`define PFS_EV_TABTSIG   2
`define PFS_EV_PAR       3
`define PFS_EV_W         4
`define PFS_CTRL_PERESP  0
`define PFS_ZERO32       32'h0000_0000
`define PFS_ZERO_EV      4'h0

`endif

/* File: common/pfs_pkg.sv */
// Types shared by the function status bank
package pfs_pkg;
  `include "pfs_map.svh"

  typedef struct packed {
    logic master_abort;
    logic target_abort_rcvd;
    logic target_abort_sent;
    logic perr_seen;
    logic bus_master;
  } pfs_evt_t;

  typedef struct packed {
    logic [`PFS_ADDR_W-1:0] address;
    logic                   read;
    logic                   write;
    logic [31:0]            writedata;
  } pfs_req_t;

  typedef enum logic [1:0] {PFS_IDLE, PFS_ANSWER} pfs_state_t;
endpackage

/* File: core/pfs_flag.sv */
// One sticky flag: hardware set wins over software write-one clear
module pfs_flag (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_q
);
  logic flag_d;

  always_comb begin
    flag_d = flag_q;
    if (clr_i) begin
      flag_d = 1'b0;
    end
    if (set_i) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule

/* File: core/pfs_sync.sv */
// Two-stage synchroniser for a bundle of levels
module pfs_sync #(
  parameter int W = 5
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_q;

  initial begin
    if (W < 1) begin
      $error("pfs_sync: width must be positive");
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= '0;
      q_o  <= '0;
    end else begin
      s1_q <= d_i;
      q_o  <= s1_q;
    end
  end
endmodule

/* File: core/pfs_status_bank.sv */
// Function status bank: sticky bus-error flags, hardwired codes, Avalon-MM slave
module pfs_status_bank
  import pfs_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  input  wire pfs_pkg::pfs_evt_t      evt_i,
  input  wire logic [`PFS_ADDR_W-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  output logic [1:0]                  avs_response,
  output logic                        irq_q
);
  import pfs_pkg::*;

  // ==========================================================================
  // Event inputs come from the bus engine pins; sync then edge-detect
  pfs_evt_t evt_s;
  pfs_evt_t evt_p_q;
  pfs_evt_t evt_p_d;

  pfs_sync #(.W(5)) u_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .d_i     (evt_i),
    .q_o     (evt_s)
  );

  always_comb begin
    evt_p_d = evt_s;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      evt_p_q <= '0;
    end else begin
      evt_p_q <= evt_p_d;
    end
  end

  // ==========================================================================
  // Bus slave: one cycle of wait, answer in the second cycle
  pfs_state_t st_q;
  pfs_state_t st_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0]  resp_q;
  logic [1:0]  resp_d;
  logic        wait_q;
  logic        wait_d;
  logic        peresp_q;
  logic        peresp_d;
  logic [`PFS_EV_W-1:0] mask_q;
  logic [`PFS_EV_W-1:0] mask_d;
  logic        irq_d;
  logic        wr_take;
  logic [15:0] status_w;
  logic [`PFS_EV_W-1:0] ev_set;
  logic [`PFS_EV_W-1:0] ev_clr;
  logic [`PFS_EV_W-1:0] st_clr;
  logic [`PFS_EV_W-1:0] ev_q;
  logic [`PFS_EV_W-1:0] fl_q;

  function automatic logic hit(input logic [`PFS_ADDR_W-1:0] a,
                               input logic [`PFS_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // Write takes effect at the edge where waitrequest is seen low
  assign wr_take = avs_write && (st_q == PFS_ANSWER);

  // ==========================================================================
  // Flag set conditions; edges so a held level counts once
  always_comb begin
    ev_set = `PFS_ZERO_EV;
    ev_set[`PFS_EV_RECEIVED_MASTER_ABORT_FLAG]  = evt_s.master_abort && !evt_p_q.master_abort;
    ev_set[`PFS_EV_TABTREC] = evt_s.target_abort_rcvd
                              && !evt_p_q.target_abort_rcvd;
    ev_set[`PFS_EV_TABTSIG] = evt_s.target_abort_sent
                              && !evt_p_q.target_abort_sent;
    // All three conditions at once, sampled together
    ev_set[`PFS_EV_PAR] = evt_s.perr_seen && !evt_p_q.perr_seen
                          && evt_s.bus_master && peresp_q;
  end

  // Clears only from write of one with the low byte lanes selected
  always_comb begin
    st_clr = `PFS_ZERO_EV;
    ev_clr = `PFS_ZERO_EV;
    if (wr_take && hit(avs_address, `PFS_OFS_STATUS)) begin
      if (avs_byteenable[1]) begin
        st_clr[`PFS_EV_RECEIVED_MASTER_ABORT_FLAG]  = avs_writedata[`PFS_BIT_RECEIVED_MASTER_ABORT_FLAG];
        st_clr[`PFS_EV_TABTREC] = avs_writedata[`PFS_BIT_TABTREC];
        st_clr[`PFS_EV_TABTSIG] = avs_writedata[`PFS_BIT_TABTSIG];
        st_clr[`PFS_EV_PAR]     = avs_writedata[`PFS_BIT_PAR];
      end
    end
    if (wr_take && hit(avs_address, `PFS_OFS_IRQ_STAT) && avs_byteenable[0]) begin
      ev_clr = avs_writedata[`PFS_EV_W-1:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `PFS_EV_W; gi++) begin : g_flag
      pfs_flag u_fl (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .set_i   (ev_set[gi]),
        .clr_i   (st_clr[gi]),
        .flag_q  (fl_q[gi])
      );
      pfs_flag u_ev (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .set_i   (ev_set[gi]),
        .clr_i   (ev_clr[gi]),
        .flag_q  (ev_q[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Status image; hardwired fields are constants and ignore writes
  always_comb begin
    status_w = 16'h0000;
    status_w[`PFS_BIT_RECEIVED_MASTER_ABORT_FLAG]  = fl_q[`PFS_EV_RECEIVED_MASTER_ABORT_FLAG];
    status_w[`PFS_BIT_TABTREC] = fl_q[`PFS_EV_TABTREC];
    status_w[`PFS_BIT_TABTSIG] = fl_q[`PFS_EV_TABTSIG];
    status_w[`PFS_BIT_TIM_HI:`PFS_BIT_TIM_LO] = `PFS_TIMING_CODE;
    status_w[`PFS_BIT_PAR] = fl_q[`PFS_EV_PAR];
    status_w[7] = `PFS_HARD_ZERO;
    status_w[6] = `PFS_HARD_ZERO;
    status_w[5] = `PFS_HARD_ZERO;
    status_w[4] = `PFS_CAPABILITY_LIST_PRESENT_VAL;
    status_w[3:0] = `PFS_RSVD_VAL;
  end

  // ==========================================================================
  // Slave sequencing, control and mask registers
  always_comb begin
    st_d     = st_q;
    rdata_d  = rdata_q;
    resp_d   = resp_q;
    wait_d   = wait_q;
    peresp_d = peresp_q;
    mask_d   = mask_q;
    case (st_q)
      PFS_IDLE: begin
        wait_d = 1'b1;
        if (avs_read || avs_write) begin
          st_d   = PFS_ANSWER;
          wait_d = 1'b0;
          resp_d = 2'b00;
          rdata_d = `PFS_ZERO32;
          if (avs_read) begin
            if (hit(avs_address, `PFS_OFS_STATUS)) begin
              rdata_d = {16'h0000, status_w};
            end else if (hit(avs_address, `PFS_OFS_IRQ_STAT)) begin
              rdata_d = {28'h0, ev_q};
            end else if (hit(avs_address, `PFS_OFS_IRQ_MASK)) begin
              rdata_d = {28'h0, mask_q};
            end else if (hit(avs_address, `PFS_OFS_CTRL)) begin
              rdata_d = {31'h0, peresp_q};
            end else begin
              resp_d = 2'b11;
            end
          end else if (!(hit(avs_address, `PFS_OFS_STATUS)
                         || hit(avs_address, `PFS_OFS_IRQ_STAT)
                         || hit(avs_address, `PFS_OFS_IRQ_MASK)
                         || hit(avs_address, `PFS_OFS_CTRL))) begin
            resp_d = 2'b11;
          end
        end
      end
      PFS_ANSWER: begin
        st_d   = PFS_IDLE;
        wait_d = 1'b1;
        if (wr_take && avs_byteenable[0]) begin
          if (hit(avs_address, `PFS_OFS_IRQ_MASK)) begin
            mask_d = avs_writedata[`PFS_EV_W-1:0];
          end
          if (hit(avs_address, `PFS_OFS_CTRL)) begin
            peresp_d = avs_writedata[`PFS_CTRL_PERESP];
          end
        end
      end
      default: begin
        st_d   = PFS_IDLE;
        wait_d = 1'b1;
      end
    endcase
    irq_d = |(ev_q & mask_q);
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q     <= PFS_IDLE;
      rdata_q  <= `PFS_ZERO32;
      resp_q   <= 2'b00;
      wait_q   <= 1'b1;
      peresp_q <= 1'b0;
      mask_q   <= `PFS_ZERO_EV;
      irq_q    <= 1'b0;
    end else begin
      st_q     <= st_d;
      rdata_q  <= rdata_d;
      resp_q   <= resp_d;
      wait_q   <= wait_d;
      peresp_q <= peresp_d;
      mask_q   <= mask_d;
      irq_q    <= irq_d;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign avs_response    = resp_q;
endmodule

/* File: tb/pfs_status_bank_asserts.sv */
// Port-level checks of the function status bank
`include "pfs_map.svh"
module pfs_chk
  import pfs_pkg::*;
(
  input wire logic                   mclk,
  input wire logic                   sys_rst,
  input wire pfs_pkg::pfs_evt_t      evt_i,
  input wire logic [`PFS_ADDR_W-1:0] avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest,
  input wire logic [1:0]             avs_response,
  input wire logic                   irq_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // ======================================================================
  // Helpers
  // Flags may only read set after their cause was seen on the pins
  logic [3:0] prev_q, seen_q, now_ev, seen_d;
  logic       st_rd;
  always_comb begin
    now_ev = {evt_i.master_abort, evt_i.target_abort_rcvd, evt_i.target_abort_sent,
              evt_i.perr_seen & evt_i.bus_master};
    seen_d = seen_q | (now_ev & ~prev_q);
    st_rd = avs_read && !avs_waitrequest && avs_address == 4'h0;
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_q <= 4'h0;
      seen_q <= 4'h0;
    end else begin
      prev_q <= now_ev;
      seen_q <= seen_d;
    end
  end
  // ======================================================================
  // Properties
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  AST_TIMING: assert property (st_rd |-> avs_readdata[10:9] == 2'h1)
    else $error("select timing code wrong");
  AST_HARD_ZEROS: assert property (st_rd |-> avs_readdata[7:5] == 3'h0)
    else $error("hardwired zero bits set");
  AST_CAP_LIST: assert property (st_rd |-> avs_readdata[4] == 1'b1)
    else $error("capability list bit not one");
  AST_RSVD: assert property (st_rd |-> avs_readdata[3:0] == 4'h0)
    else $error("reserved bits not zero");
  AST_RECEIVED_MASTER_ABORT_FLAG: assert property (st_rd && avs_readdata[13] |-> seen_q[3])
    else $error("master abort flag without cause");
  AST_TABT_RCVD: assert property (st_rd && avs_readdata[12] |-> seen_q[2])
    else $error("received target abort flag without cause");
  AST_TABT_SENT: assert property (st_rd && avs_readdata[11] |-> seen_q[1])
    else $error("signaled target abort flag without cause");
  AST_PARITY: assert property (st_rd && avs_readdata[8] |-> seen_q[0])
    else $error("parity flag without error while mastering");
  cover property (st_rd && avs_readdata[13]);
  cover property (st_rd && avs_readdata[8]);
  cover property ($rose(irq_q));
endmodule
bind pfs_status_bank pfs_chk pfs_chk_i (
  .mclk(mclk), .sys_rst(sys_rst), .evt_i(evt_i), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .irq_q(irq_q));

/* File: tb/pfs_bus_agent.sv */
// Bus-side agent that raises the error event levels
module pfs_bus_agent
  import pfs_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic [3:0]  pulse,
  input  wire logic        master,
  output pfs_pkg::pfs_evt_t evt
);
  timeunit 1ns;
  timeprecision 1ps;
  // ======================================================================
  // Registered like real bus logic; mastership held around each error
  always_ff @(posedge mclk) begin
    evt <= {pulse, master};
  end
endmodule

/* File: tb/tb.sv */
// Self-checking bench of the function status bank
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pfs_pkg::*;
  logic        mclk, sys_rst, avs_read, avs_write, avs_waitrequest, irq_q, master;
  logic [3:0]  avs_address, avs_byteenable, pulse;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [1:0]  avs_response, r;
  pfs_evt_t    evt;
  int          bad_count, cmp_count, exp_st, exp_is, mask, ctrl;
  // ======================================================================
  // Instances
  pfs_status_bank pfs_status_bank_i (.mclk(mclk), .sys_rst(sys_rst), .evt_i(evt),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .irq_q(irq_q));
  pfs_bus_agent pfs_bus_agent_i (.mclk(mclk), .pulse(pulse), .master(master), .evt(evt));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // ======================================================================
  // Tasks
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      $display("Error at %0t: seen %h expected %h", $time, s, e);
      bad_count++;
    end
  endtask
  // Extra edge at the end keeps back-to-back calls from driving twice in one step
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      bad_count++;
      test_done();
    end
    q = avs_readdata;
    r = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [3:0] a, input int d);
    bus(1'b1, a, d);
    case (a)
      4'h0: exp_st &= ~d;
      4'h4: exp_is &= ~d;
      4'h8: mask = d & 15;
      4'hc: ctrl = d & 1;
      default: ;
    endcase
  endtask
  task automatic fire(input int k, input logic m);
    master <= m;
    @(posedge mclk);
    pulse <= 4'h8 >> k;
    repeat (2) @(posedge mclk);
    pulse <= 4'h0;
    repeat (6) @(posedge mclk);
    if (k < 3 || (m && ctrl[0])) begin
      exp_st |= 1 << (k == 3 ? 8 : 13 - k);
      exp_is |= 1 << k;
    end
    bus(1'b0, 4'h0, 32'h0);
  endtask
  // ======================================================================
  // Sequence
  initial begin
    sys_rst = 1'b1;
    {avs_read, avs_write, master, pulse, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hf;
    void'($urandom(81));
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    for (int a = 0; a < 16; a += 4) begin
      bus(1'b0, 4'(a), 32'h0);
      chk(q, a == 0 ? 32'h210 : 32'h0);
    end
    wr(4'h0, -1);
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h210);
    wr(4'h8, 15);
    fire(3, 1'b1);
    chk(q, 32'h210);
    wr(4'hc, 1);
    fire(3, 1'b0);
    chk(q, 32'h210);
    fire(3, 1'b1);
    chk(q, 32'h310);
    for (int k = 0; k < 3; k++) begin
      fire(k, 1'($urandom));
      chk(q, 32'h210 | exp_st);
      chk(32'(irq_q), 32'h1);
    end
    bus(1'b0, 4'h4, 32'h0);
    chk(q, exp_is);
    bus(1'b0, 4'h8, 32'h0);
    chk(q, mask);
    bus(1'b0, 4'hc, 32'h0);
    chk(q, ctrl);
    repeat (4) begin
      wr(4'h0, $urandom);
      bus(1'b0, 4'h0, 32'h0);
      chk(q, 32'h210 | exp_st);
    end
    wr(4'h8, 0);
    repeat (2) @(posedge mclk);
    chk(32'(irq_q), 32'h0);
    wr(4'h8, 15);
    repeat (2) @(posedge mclk);
    chk(32'(irq_q), 32'h1);
    wr(4'h4, 15);
    repeat (2) @(posedge mclk);
    chk(32'(irq_q), 32'h0);
    bus(1'b0, 4'h2, 32'h0);
    chk(32'(r), 32'h3);
    chk(q, 32'h0);
    test_done();
  end
endmodule
